// ==== logic/watchdog_pkg.sv ====
// watchdog package: register map, field positions, command codes, counts
// assumes a 32-bit axi4-lite slave with a 4-bit byte address
package watchdog_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 32;
  localparam logic [3:0]  STATUS_OFF      = 4'h0;
  localparam logic [3:0]  COMMAND_OFF     = 4'h4;
  localparam logic [3:0]  COUNT_OFF       = 4'h8;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // status register fields
  localparam int          ST_TIMEOUT_BIT  = 0;
  localparam int          ST_PD_FLAG_BIT  = 1;
  localparam int          ST_IN_PD_BIT    = 2;
  localparam int          ST_OPT_EN_BIT   = 3;
  localparam int          ST_OPT_OSC_BIT  = 4;
  localparam int          ST_OPT_TWO_BIT  = 5;

  ////////////////////////////////////////////////////////////////////////////
  // instruction codes written to the command register, low byte
  localparam logic [7:0]  CMD_CLEAR_SINGLE = 8'h01;
  localparam logic [7:0]  CMD_CLEAR_FIRST  = 8'h02;
  localparam logic [7:0]  CMD_CLEAR_SECOND = 8'h03;
  localparam logic [7:0]  CMD_HALT         = 8'h04;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int          WATCHDOG_PRESCALE_BITS = 15;
  localparam logic [1:0]  INSTR_DIV_LAST    = 2'h3;  // divide by four
  localparam logic [14:0] PRESCALE_RESET    = 15'h0000;
  localparam logic [1:0]  DIV_RESET         = 2'h0;
  localparam logic [31:0] DATA_RESET        = 32'h0000_0000;

endpackage : watchdog_pkg

// ==== logic/pin_sync.sv ====
// three-stage synchroniser for a pin from outside the aclk domain
// assumes aclk runs far faster than the pin toggles
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin_in,
  output var  logic level_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic stable;
  } sync_t;

  sync_t s_reg;
  sync_t s_next;

  // s1 is read only by s2; the level moves once s2 and s3 agree
  always_comb begin
    s_next    = s_reg;
    s_next.s1 = pin_in;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    if (s_reg.s2 == s_reg.s3) begin
      s_next.stable = s_reg.s3;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '{RESET_LEVEL, RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
    end else begin
      s_reg <= s_next;
    end
  end

  assign level_out = s_reg.stable;

endmodule : pin_sync

`default_nettype wire

// ==== logic/watchdog_reset_timer.sv ====
// watchdog reset timer with axi4-lite status and instruction port
// assumes the core posts its clear and halt instructions as command writes
// and that option straps are steady while aresetn is low
//
// Behaviour
// - the count runs from the internal oscillator pin or from the instruction clock, by option.
// - with the watchdog option off, the clear instructions do nothing; halt still enters power-down and sets its flags.
// - a 15-bit prescaler and a clearable final bit give a time-out of 2^15 to 2^16 ticks.
// - a software clear zeroes only the final bit and leaves the prescaler count.
// - overflow while running pulses the device reset and sets the time-out flag.
// - overflow in power-down sets the time-out flag and pulses only the pc and stack reset.
// - the count is cleared by the external reset pin and halt; the clear instructions zero only the final bit.
// - an option picks single-instruction or two-instruction clearing.
// - in two-instruction mode only the opposite instruction completes a clear.
// - on the instruction clock the count stops during power-down.
// - enable, source and clear mode are caught once after reset and never change.
// - no register sets the period; it depends only on the tick rate.
// - the instruction clock is one enable pulse per four system clocks.
// - halt clears the count; it keeps running on the oscillator and stops otherwise.
// - halt sets the power-down flag and clears the time-out flag; a clear resets it.
`timescale 1ns/1ps
`default_nettype none

module watchdog_reset_timer
  import watchdog_pkg::*;
#(
  parameter int PRESCALE_BITS = WATCHDOG_PRESCALE_BITS
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axil_awaddr,
  input  wire logic              s_axil_awvalid,
  output var  logic              s_axil_awready,
  input  wire logic [DATA_W-1:0] s_axil_wdata,
  input  wire logic [3:0]        s_axil_wstrb,
  input  wire logic              s_axil_wvalid,
  output var  logic              s_axil_wready,
  output var  logic [1:0]        s_axil_bresp,
  output var  logic              s_axil_bvalid,
  input  wire logic              s_axil_bready,
  input  wire logic [ADDR_W-1:0] s_axil_araddr,
  input  wire logic              s_axil_arvalid,
  output var  logic              s_axil_arready,
  output var  logic [DATA_W-1:0] s_axil_rdata,
  output var  logic [1:0]        s_axil_rresp,
  output var  logic              s_axil_rvalid,
  input  wire logic              s_axil_rready,
  input  wire logic              opt_watchdog_enable,
  input  wire logic              opt_clock_osc,
  input  wire logic              opt_clear_two,
  input  wire logic              watchdog_osc_in,
  input  wire logic              external_reset_pin_n,
  output var  logic              device_reset,
  output var  logic              pc_stack_reset,
  output var  logic              timeout_flag,
  output var  logic              power_down_flag,
  output var  logic              power_down
);

  localparam logic [14:0] PRESCALE_MAX = 15'((32'h1 << PRESCALE_BITS) - 32'h1);

  typedef struct packed {
    logic              opt_loaded;
    logic              opt_enable;
    logic              opt_osc;
    logic              opt_two;
    logic [1:0]        div_cnt;
    logic              osc_prev;
    logic [14:0]       prescale;
    logic              final_stage;
    logic              first_seen;
    logic              second_seen;
    logic              timeout_flag;
    logic              power_down_flag;
    logic              in_power_down;
    logic              device_reset;
    logic              pc_stack_reset;
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [DATA_W-1:0] w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } watchdog_state_t;

  watchdog_state_t s_reg;
  watchdog_state_t s_next;

  logic osc_level;
  logic ext_level;
  logic ext_rst_active;
  logic instr_tick;
  logic osc_rise;
  logic wd_tick;
  logic wr_commit;
  logic cmd_single;
  logic cmd_first;
  logic cmd_second;
  logic cmd_halt;
  logic sw_clear;
  logic overflow;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] count_word;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  pin_sync #(.RESET_LEVEL(1'b0)) u_osc_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    (watchdog_osc_in),
    .level_out (osc_level)
  );

  pin_sync #(.RESET_LEVEL(1'b1)) u_ext_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    (external_reset_pin_n),
    .level_out (ext_level)
  );

  assign ext_rst_active = !ext_level;

  ////////////////////////////////////////////////////////////////////////////
  // tick sources and instruction decode

  // system clock is halted in power-down, so the instruction clock stops too
  assign instr_tick = (s_reg.div_cnt == INSTR_DIV_LAST) && !s_reg.in_power_down;
  assign osc_rise   = osc_level && !s_reg.osc_prev;
  assign wd_tick    = s_reg.opt_loaded && s_reg.opt_enable &&
                      (s_reg.opt_osc ? osc_rise : instr_tick);

  assign wr_commit  = s_reg.aw_held && s_reg.w_held;
  assign cmd_single = wr_commit && (s_reg.aw_addr == COMMAND_OFF) && s_reg.w_strb[0] &&
                      (s_reg.w_data[7:0] == CMD_CLEAR_SINGLE);
  assign cmd_first  = wr_commit && (s_reg.aw_addr == COMMAND_OFF) && s_reg.w_strb[0] &&
                      (s_reg.w_data[7:0] == CMD_CLEAR_FIRST);
  assign cmd_second = wr_commit && (s_reg.aw_addr == COMMAND_OFF) && s_reg.w_strb[0] &&
                      (s_reg.w_data[7:0] == CMD_CLEAR_SECOND);
  assign cmd_halt   = wr_commit && (s_reg.aw_addr == COMMAND_OFF) && s_reg.w_strb[0] &&
                      (s_reg.w_data[7:0] == CMD_HALT);

  // a clear that never completes in two-instruction mode is the core's fault
  always_comb begin
    sw_clear = 1'b0;
    if (s_reg.opt_loaded && s_reg.opt_enable) begin
      if (s_reg.opt_two) begin
        sw_clear = (cmd_first && s_reg.second_seen) ||
                   (cmd_second && s_reg.first_seen);
      end else begin
        sw_clear = cmd_single;
      end
    end
  end

  // a clear or halt in the overflow cycle wins, the core was in time
  assign overflow = wd_tick && (s_reg.prescale == PRESCALE_MAX) && s_reg.final_stage &&
                    !sw_clear && !cmd_halt && !ext_rst_active;

  assign status_word = {26'h0000000,
                        s_reg.opt_two, s_reg.opt_osc, s_reg.opt_enable,
                        s_reg.in_power_down, s_reg.power_down_flag,
                        s_reg.timeout_flag};
  assign count_word  = {16'h0000, s_reg.final_stage, s_reg.prescale};

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_next                = s_reg;
    s_next.device_reset   = 1'b0;
    s_next.pc_stack_reset = 1'b0;
    s_next.osc_prev       = osc_level;

    // options are caught once, then only aresetn reloads them
    if (!s_reg.opt_loaded) begin
      s_next.opt_loaded = 1'b1;
      s_next.opt_enable = opt_watchdog_enable;
      s_next.opt_osc    = opt_clock_osc;
      s_next.opt_two    = opt_clear_two;
    end

    if (!s_reg.in_power_down) begin
      s_next.div_cnt = s_reg.div_cnt + 2'h1;
    end

    // two-instruction bookkeeping
    if (s_reg.opt_enable && s_reg.opt_two) begin
      if (sw_clear) begin
        s_next.first_seen  = 1'b0;
        s_next.second_seen = 1'b0;
      end else if (cmd_first) begin
        s_next.first_seen  = 1'b1;
      end else if (cmd_second) begin
        s_next.second_seen = 1'b1;
      end
    end

    // count chain
    if (wd_tick) begin
      if (s_reg.prescale == PRESCALE_MAX) begin
        s_next.prescale    = PRESCALE_RESET;
        s_next.final_stage = !s_reg.final_stage;
      end else begin
        s_next.prescale = s_reg.prescale + 15'h0001;
      end
    end
    if (sw_clear) begin
      s_next.final_stage     = 1'b0;
      s_next.power_down_flag = 1'b0;
    end

    if (cmd_halt) begin
      s_next.in_power_down   = 1'b1;
      s_next.power_down_flag = 1'b1;
      s_next.timeout_flag    = 1'b0;
      if (s_reg.opt_enable) begin
        s_next.prescale    = PRESCALE_RESET;
        s_next.final_stage = 1'b0;
        s_next.first_seen  = 1'b0;
        s_next.second_seen = 1'b0;
      end
    end

    if (ext_rst_active) begin
      s_next.prescale      = PRESCALE_RESET;
      s_next.final_stage   = 1'b0;
      s_next.first_seen    = 1'b0;
      s_next.second_seen   = 1'b0;
      s_next.in_power_down = 1'b0;
    end

    // halt in the same cycle blocks the overflow, so its flag clear wins
    if (overflow) begin
      s_next.timeout_flag = 1'b1;
      s_next.first_seen   = 1'b0;
      s_next.second_seen  = 1'b0;
      if (s_reg.in_power_down) begin
        s_next.pc_stack_reset = 1'b1;
        s_next.in_power_down  = 1'b0;
      end else begin
        s_next.device_reset = 1'b1;
      end
    end

    // axi4-lite write channels, taken in either order
    if (s_axil_awvalid && s_axil_awready) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready) begin
      s_next.w_held = 1'b1;
      s_next.w_data = s_axil_wdata;
      s_next.w_strb = s_axil_wstrb;
    end
    if (wr_commit) begin
      s_next.aw_held = 1'b0;
      s_next.w_held  = 1'b0;
      s_next.bvalid  = 1'b1;
      if ((s_reg.aw_addr == STATUS_OFF) || (s_reg.aw_addr == COMMAND_OFF) ||
          (s_reg.aw_addr == COUNT_OFF)) begin
        s_next.bresp = RESP_OKAY;
      end else begin
        s_next.bresp = RESP_SLVERR;
      end
    end else if (s_reg.bvalid && s_axil_bready) begin
      s_next.bvalid = 1'b0;
    end

    // axi4-lite read
    if (s_axil_arvalid && s_axil_arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      case (s_axil_araddr)
        STATUS_OFF:  s_next.rdata = status_word;
        COMMAND_OFF: s_next.rdata = DATA_RESET;
        COUNT_OFF:   s_next.rdata = count_word;
        default: begin
          s_next.rdata = DATA_RESET;
          s_next.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_reg.rvalid && s_axil_rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '{opt_loaded: 1'b0, opt_enable: 1'b0, opt_osc: 1'b0, opt_two: 1'b0,
                 div_cnt: DIV_RESET, osc_prev: 1'b0, prescale: PRESCALE_RESET,
                 final_stage: 1'b0, first_seen: 1'b0, second_seen: 1'b0,
                 timeout_flag: 1'b0, power_down_flag: 1'b0, in_power_down: 1'b0,
                 device_reset: 1'b0, pc_stack_reset: 1'b0, aw_held: 1'b0,
                 aw_addr: STATUS_OFF, w_held: 1'b0, w_data: DATA_RESET, w_strb: 4'h0,
                 bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0, rdata: DATA_RESET,
                 rresp: RESP_OKAY};
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axil_awready  = !s_reg.aw_held && !s_reg.bvalid;
  assign s_axil_wready   = !s_reg.w_held && !s_reg.bvalid;
  assign s_axil_bvalid   = s_reg.bvalid;
  assign s_axil_bresp    = s_reg.bresp;
  assign s_axil_arready  = !s_reg.rvalid;
  assign s_axil_rvalid   = s_reg.rvalid;
  assign s_axil_rdata    = s_reg.rdata;
  assign s_axil_rresp    = s_reg.rresp;
  assign device_reset    = s_reg.device_reset;
  assign pc_stack_reset  = s_reg.pc_stack_reset;
  assign timeout_flag    = s_reg.timeout_flag;
  assign power_down_flag = s_reg.power_down_flag;
  assign power_down      = s_reg.in_power_down;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_opts_fixed;
    s_reg.opt_loaded && $past(s_reg.opt_loaded) |->
      $stable(s_reg.opt_enable) && $stable(s_reg.opt_osc) && $stable(s_reg.opt_two);
  endproperty
  a_opts_fixed: assert property (p_opts_fixed) else $error("options changed");

  property p_disabled_idle;
    s_reg.opt_loaded && !s_reg.opt_enable |-> !wd_tick && !sw_clear && !overflow;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("disabled watchdog acted");

  property p_div_four;
    instr_tick |=> !instr_tick [*3];
  endproperty
  a_div_four: assert property (p_div_four) else $error("instr tick not 1 in 4");

  property p_osc_source;
    wd_tick && s_reg.opt_osc |-> osc_rise;
  endproperty
  a_osc_source: assert property (p_osc_source) else $error("osc tick w/o edge");

  property p_pd_stop;
    s_reg.in_power_down && !s_reg.opt_osc && !ext_rst_active && !cmd_halt |=>
      $stable(s_reg.prescale);
  endproperty
  a_pd_stop: assert property (p_pd_stop) else $error("count ran in power-down");

  property p_over_run;
    overflow && !s_reg.in_power_down |=>
      device_reset && !pc_stack_reset && timeout_flag ##1 !device_reset;
  endproperty
  a_over_run: assert property (p_over_run) else $error("bad run time-out");

  property p_over_pd;
    overflow && s_reg.in_power_down |=>
      pc_stack_reset && !device_reset && timeout_flag && !power_down;
  endproperty
  a_over_pd: assert property (p_over_pd) else $error("bad power-down time-out");

  property p_clear_final;
    sw_clear && !wd_tick && !cmd_halt && !ext_rst_active |=>
      !s_reg.final_stage && (s_reg.prescale == $past(s_reg.prescale));
  endproperty
  a_clear_final: assert property (p_clear_final) else $error("clear hit prescaler");

  property p_ext_clear;
    ext_rst_active |=> (s_reg.prescale == PRESCALE_RESET) && !s_reg.final_stage;
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("ext reset kept count");

  property p_two_repeat;
    s_reg.opt_two && cmd_first && !s_reg.second_seen |-> !sw_clear;
  endproperty
  a_two_repeat: assert property (p_two_repeat) else $error("repeat first cleared");

  property p_single;
    s_reg.opt_loaded && s_reg.opt_enable && !s_reg.opt_two |-> (sw_clear == cmd_single);
  endproperty
  a_single: assert property (p_single) else $error("single clear mismatch");

  property p_halt;
    cmd_halt && s_reg.opt_enable && !overflow && !ext_rst_active |=>
      power_down_flag && !timeout_flag && power_down &&
      (s_reg.prescale == PRESCALE_RESET) && !s_reg.final_stage;
  endproperty
  a_halt: assert property (p_halt) else $error("halt effects wrong");

  property p_over_wrap;
    overflow |=> (s_reg.prescale == PRESCALE_RESET) && !s_reg.final_stage;
  endproperty
  a_over_wrap: assert property (p_over_wrap) else $error("overflow did not wrap");

  c_run_reset: cover property (overflow && !s_reg.in_power_down);
  c_pd_wake:   cover property (overflow && s_reg.in_power_down);
  c_two_clear: cover property (s_reg.opt_two && sw_clear);
  c_halt:      cover property (cmd_halt ##1 power_down);

endmodule : watchdog_reset_timer

`default_nettype wire

// ==== testbench/core_model.sv ====
// processor core model: posts clear and halt instructions as axi4-lite transfers
// assumes each task is entered just after a rising edge of aclk
`timescale 1ns/1ps
`default_nettype none

module core_model (
  input  wire logic        aclk,
  output var  logic [3:0]  awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [3:0]  araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready,
  output var  logic        hang
);
  // ready for answers is held high throughout, so back-to-back calls never toggle it
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid} = '0;
    {araddr, arvalid, hang} = '0;
    bready = 1'b1;
    rready = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // each channel is judged at the rising edge, before that edge updates ready
  task automatic write_word(input logic [3:0] a, input logic [31:0] v, output logic [1:0] r);
    logic b_ok;
    b_ok = 1'b0;
    r = 2'h3;
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int i = 0; i < 100 && !b_ok; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        b_ok = 1'b1;
        r = bresp;
      end
    end
    if (!b_ok) hang <= 1'b1;
  endtask : write_word

  task automatic read_word(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
    logic r_ok;
    r_ok = 1'b0;
    v = 32'h0;
    r = 2'h3;
    araddr <= a;
    arvalid <= 1'b1;
    for (int i = 0; i < 100 && !r_ok; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        r_ok = 1'b1;
        v = rdata;
        r = rresp;
      end
    end
    if (!r_ok) hang <= 1'b1;
  endtask : read_word
endmodule : core_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// testbench: watchdog reset timer driven by the core model over axi4-lite
// assumes PRESCALE_BITS of 4, so a time-out spans 16 to 32 ticks
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import watchdog_pkg::*;
  localparam int B = 4;
  logic aclk = 1'b0, aresetn = 1'b0, opt_watchdog_enable = 1'b0, opt_clock_osc = 1'b0;
  logic opt_clear_two = 1'b0, watchdog_osc_in = 1'b0, external_reset_pin_n = 1'b1;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d, c;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, hang, device_reset, pc_stack_reset, timeout_flag;
  logic power_down_flag, power_down;
  logic [2:0] osc_cnt = 3'h0;
  int n_fail = 0, checks = 0, dev_cnt = 0, n;

  watchdog_reset_timer #(.PRESCALE_BITS(B)) watchdog_reset_timer_i (.aclk(aclk),
    .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb),
    .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
    .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
    .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
    .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
    .opt_watchdog_enable(opt_watchdog_enable), .opt_clock_osc(opt_clock_osc),
    .opt_clear_two(opt_clear_two), .watchdog_osc_in(watchdog_osc_in),
    .external_reset_pin_n(external_reset_pin_n), .device_reset(device_reset),
    .pc_stack_reset(pc_stack_reset), .timeout_flag(timeout_flag),
    .power_down_flag(power_down_flag), .power_down(power_down));

  core_model core_model_i (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .hang(hang));

  ////////////////////////////////////////////////////////////////////////////
  // oscillator pin: period of 8 aclk, each level 4 aclk, one above the three-stage sync depth
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    osc_cnt <= osc_cnt + 3'h1;
    watchdog_osc_in <= osc_cnt[2];
  end
  always @(posedge aclk) if (device_reset === 1'b1) dev_cnt <= dev_cnt + 1;
  always @(posedge hang) begin
    n_fail = n_fail + 1;
    results();
  end

  task automatic results;
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    core_model_i.write_word(a, {24'h0, v}, r);
    check("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask : wr

  task automatic rd(input logic [3:0] a);
    core_model_i.read_word(a, d, r);
  endtask : rd

  // bounded wait for a reset pulse; n is left at bound when none came
  task automatic wait_for(input logic pc, input int bound);
    for (n = 0; n < bound; n++) begin
      @(negedge aclk);
      if ((pc ? pc_stack_reset : device_reset) === 1'b1) break;
    end
    @(posedge aclk);
  endtask : wait_for

  task automatic restart(input logic e, input logic o, input logic t);
    aresetn <= 1'b0;
    opt_watchdog_enable <= e;
    opt_clock_osc <= o;
    opt_clear_two <= t;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : restart

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    restart(1'b1, 1'b0, 1'b0);
    wait_for(1'b0, 300);
    check("instr_timeout", 32'h1, {31'h0, n >= 120 && n <= 136});
    check("timeout_flag", 32'h1, {31'h0, timeout_flag});
    rd(STATUS_OFF);
    check("status", 32'h9, d);
    rd(4'hC);
    check("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(STATUS_OFF, 8'hFF);
    rd(STATUS_OFF);
    check("status_ro", 32'h9, d);
    c = 32'(dev_cnt);
    // clears come well inside the shortest time-out
    repeat (12) begin
      wr(COMMAND_OFF, CMD_CLEAR_SINGLE);
      wait_for(1'b0, 30);
    end
    check("cleared_runs", c, 32'(dev_cnt));
    wr(COMMAND_OFF, CMD_HALT);
    rd(STATUS_OFF);
    check("halt_status", 32'hE, d);
    rd(COUNT_OFF);
    c = d;
    check("halt_clears", 32'h0, c);
    wait_for(1'b1, 300);
    rd(COUNT_OFF);
    check("count_frozen", c, d);
    check("no_pc_reset", 32'd300, 32'(n));
    external_reset_pin_n <= 1'b0;
    repeat (8) @(posedge aclk);
    external_reset_pin_n <= 1'b1;
    repeat (8) @(posedge aclk);
    check("pin_wakes", 32'h1, {30'h0, power_down, power_down_flag});
    wr(COMMAND_OFF, CMD_CLEAR_SINGLE);
    check("pdf_cleared", 32'h0, {31'h0, power_down_flag});

    restart(1'b1, 1'b1, 1'b1);
    rd(STATUS_OFF);
    check("status_opts", 32'h38, d);
    c = 32'(dev_cnt);
    wr(COMMAND_OFF, CMD_HALT);
    wait_for(1'b1, 700);
    check("pd_timeout", 32'h1, {31'h0, n >= 240 && n <= 280});
    check("pd_flags", 32'h6, {29'h0, timeout_flag, power_down_flag, power_down});
    // first then second, then second then first; a repeat or a single code must not clear
    for (int k = 0; k < 2; k++) begin
      rd(COUNT_OFF);
      for (int i = 0; i < 100 && d[15] !== 1'b1; i++) rd(COUNT_OFF);
      check("final_set", 32'h1, {31'h0, d[15]});
      wr(COMMAND_OFF, k ? CMD_CLEAR_SECOND : CMD_CLEAR_FIRST);
      wr(COMMAND_OFF, k ? CMD_CLEAR_SECOND : CMD_CLEAR_FIRST);
      wr(COMMAND_OFF, CMD_CLEAR_SINGLE);
      rd(COUNT_OFF);
      check("first_only", 32'h1, {31'h0, d[15]});
      check("pdf_kept", {31'h0, k == 0}, {31'h0, power_down_flag});
      wr(COMMAND_OFF, k ? CMD_CLEAR_FIRST : CMD_CLEAR_SECOND);
      rd(COUNT_OFF);
      check("pair_clears", 32'h0, {31'h0, d[15]});
      check("pdf_pair", 32'h0, {31'h0, power_down_flag});
    end
    check("no_dev_reset", c, 32'(dev_cnt));

    restart(1'b0, 1'b0, 1'b0);
    wr(COMMAND_OFF, CMD_CLEAR_SINGLE);
    wait_for(1'b0, 400);
    check("disabled", 32'd400, 32'(n));
    results();
  end
endmodule : testbench
`default_nettype wire
